// >>> spm_top.sv
// Purpose: Full-duplex serial port, controller or target, APB registers
// Assumes: Serial pins are asynchronous and pass two flip-flops
// Notes:   Eight-bit transfers, most significant bit first
//
// The APB register port is this design's own decision.
`include "spm_defines.svh"
`default_nettype none

// Contract
// RL1 - Role bit set makes controller driving clock; clear makes target
// RL2 - Only the controller starts transfers, on a data register write
// RL3 - Byte written with shift register empty loads at once, sets empty flag
// RL4 - Controller shifts out on data out while shifting in from target
// RL5 - Received byte copied to receive register as receiver full sets
// RL6 - Receiver full clears only on status read then data read
// RL7 - Any data register write clears the transmitter empty flag
// RL8 - Two rate bits pick bus clock divided by 2, 8, 32, 128
// RL9 - Controller holds target select low for the whole transfer; the block has no select output, only the select input
// RL10 - Target copies a complete byte to receive register, sets full
// RL11 - Target software reads data before next byte completes; here a read after bit 1 of the next byte is captured already gives overrun
// RL12 - Target clock may be any rate up to the bus clock; here it is sampled on the bus clock, so half of that at most
// RL13 - Late target load resends the byte left in the shift register
// RL14 - Byte written during a target transfer waits until it ends
// RL15 - Target starts on first clock edge (phase set) or select fall
// RL16 - Clock line rests idle before a target is enabled
// RL17 - Set role first; enable controller first, disable it last
// RL18 - Unselected target leaves its data output undriven
// RL19 - Controller watches select input and flags contention as fault
// RL20 - Interrupt requests for full, empty, fault and overrun
// RL21 - Most significant bit goes out first
// RL22 - With phase clear, select toggles between bytes
// RL23 - Unread data at bit 1 capture sets overrun, new byte dropped
// RL24 - Controller start within one bit time of the data write
// RL25 - Transfers are eight bits; all buffers are eight bits
module spm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe,
    input  wire logic        ss_n_in,
    output logic             irq_rx,
    output logic             irq_tx
);
    import spm_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    spm_state_t  state_q;
    logic [7:0]  ctrl_q;
    logic [3:0]  stat_w_q;
    logic [7:0]  tx_buf_q, txsh_q, rxsh_q, rx_buf_q;
    logic        tx_empty_q, rx_full_q, ovr_q, select_fault_flag_q, drop_q, stat_rd_q;
    logic [3:0]  h_q;
    logic        samp_q, sclk_q, sclk_p_q, ss_p_q;
    logic        mosi_oe_q, miso_oe_q, sclk_oe_q, irq_rx_q, irq_tx_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic [3:0]  sync1_q, sync2_q;
    logic [3:0]  pin_in;
    logic        role, en, clock_phase_bit, clock_polarity_bit, tick;
    logic        sclk_s, ss_n_s, din, sclk_edge, ss_fall, ss_rise;
    logic        ev, cap, shf, done, bit1_cap, load, start_s;
    logic        acc, sel_c, sel_s, sel_d, hit;
    logic        wr_ctrl, wr_stat, wr_data, rd_stat, rd_data, select_fault_flag_set;
    logic [7:0]  rx_byte, rd_mux;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pin_in = {ss_n_in, miso_in, mosi_in, sclk_in};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1_q[i] <= 1'b1;
                sync2_q[i] <= 1'b1;
            end else begin
                sync1_q[i] <= pin_in[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    assign sclk_s = sync2_q[0];
    assign ss_n_s = sync2_q[3];
    assign din    = role ? sync2_q[2] : sync2_q[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_p_q <= 1'b0;
            ss_p_q   <= 1'b1;
        end else begin
            sclk_p_q <= sclk_s;
            ss_p_q   <= ss_n_s;
        end
    end

    assign sclk_edge = sclk_s ^ sclk_p_q;
    assign ss_fall   = ss_p_q & ~ss_n_s;
    assign ss_rise   = ~ss_p_q & ss_n_s;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign acc     = psel & penable & pready_q;
    assign sel_c   = paddr == {`SPM_IDX_CTRL, 2'b00};
    assign sel_s   = paddr == {`SPM_IDX_STAT, 2'b00};
    assign sel_d   = paddr == {`SPM_IDX_DATA, 2'b00};
    assign hit     = sel_c | sel_s | sel_d;
    assign wr_ctrl = acc & pwrite & sel_c;
    assign wr_stat = acc & pwrite & sel_s;
    assign wr_data = acc & pwrite & sel_d;
    assign rd_stat = acc & ~pwrite & sel_s;
    assign rd_data = acc & ~pwrite & sel_d;

    always_comb begin
        rd_mux = 8'h00;
        if (sel_c)
            rd_mux = ctrl_q;
        if (sel_s)
            rd_mux = {rx_full_q, stat_w_q[3], ovr_q, select_fault_flag_q, tx_empty_q, stat_w_q[2:0]};
        if (sel_d)
            rd_mux = rx_buf_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit;
            prdata_q  <= (psel & penable & ~pready_q) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    assign role     = ctrl_q[`SPM_C_ROLE];
    assign en       = ctrl_q[`SPM_C_EN];
    assign clock_phase_bit     = ctrl_q[`SPM_C_CLOCK_PHASE_BIT];
    assign clock_polarity_bit     = ctrl_q[`SPM_C_CLOCK_POLARITY_BIT];
    assign select_fault_flag_set = en & role & stat_w_q[`SPM_S_MODFEN] & ~ss_n_s;    // RL19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= `SPM_CTRL_RST;
        else if (select_fault_flag_set)
            ctrl_q[`SPM_C_EN] <= 1'b0;    // RL19
        else if (wr_ctrl)
            ctrl_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stat_w_q <= `SPM_STAT_W_RST;
        else if (wr_stat)
            stat_w_q <= {pwdata[`SPM_S_ERRIE], pwdata[2:0]};
    end

    spm_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (en & role),
        .rate    (stat_w_q[1:0]),    // RL8
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    assign ev       = (state_q == SPM_RUN) & (role ? tick : (sclk_edge & ~ss_n_s));    // RL4
    assign cap      = ev & (h_q[0] == clock_phase_bit);
    assign shf      = ev & (h_q[0] != clock_phase_bit);
    assign done     = clock_phase_bit ? (cap & h_q == `SPM_LAST_HALF) : (shf & h_q == `SPM_LAST_HALF);    // RL25
    assign bit1_cap = cap & (h_q == (clock_phase_bit ? 4'd13 : 4'd12));
    assign rx_byte  = clock_phase_bit ? {rxsh_q[6:0], din} : {rxsh_q[6:0], samp_q};
    assign load     = en & (state_q == SPM_IDLE) & ~tx_empty_q;    // RL3 RL14
    assign start_s  = en & ~role & (state_q == SPM_IDLE) & ~ss_n_s
                      & (clock_phase_bit ? sclk_edge : ss_fall);    // RL15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SPM_IDLE;
            h_q     <= 4'd0;
        end else if (!en || select_fault_flag_set || (!role && !clock_phase_bit && ss_rise)) begin
            state_q <= SPM_IDLE;
            h_q     <= 4'd0;
        end else if (role && load) begin
            state_q <= SPM_RUN;    // RL2 RL24
            h_q     <= 4'd0;
        end else if (start_s) begin
            state_q <= SPM_RUN;
            h_q     <= clock_phase_bit ? 4'd1 : 4'd0;    // RL15
        end else if (done) begin
            state_q <= SPM_IDLE;
            h_q     <= 4'd0;
        end else if (ev) begin
            h_q <= h_q + 4'd1;
        end
    end

    // ----------------------------------------------------------------
    // Shift registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txsh_q <= 8'h00;
            rxsh_q <= 8'h00;
            samp_q <= 1'b0;
        end else begin
            if (load)
                txsh_q <= tx_buf_q;    // RL3 RL13
            else if ((shf && !(clock_phase_bit && h_q == 4'd0)) || (clock_phase_bit && done))
                txsh_q <= {txsh_q[6:0], txsh_q[7]};    // RL21 RL13
            if (cap && !clock_phase_bit)
                samp_q <= din;
            if (cap && clock_phase_bit)
                rxsh_q <= {rxsh_q[6:0], din};    // RL4
            else if (shf && !clock_phase_bit)
                rxsh_q <= {rxsh_q[6:0], samp_q};
        end
    end

    // ----------------------------------------------------------------
    // Buffers and flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q   <= 8'h00;
            tx_empty_q <= 1'b1;
        end else begin
            if (wr_data)
                tx_buf_q <= pwdata[7:0];    // RL14
            if (wr_data)
                tx_empty_q <= 1'b0;    // RL7
            else if (load)
                tx_empty_q <= 1'b1;    // RL3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stat_rd_q <= 1'b0;
        else if (rd_stat)
            stat_rd_q <= 1'b1;
        else if (rd_data || wr_ctrl)
            stat_rd_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q  <= 8'h00;
            rx_full_q <= 1'b0;
        end else if (done && !drop_q && !(bit1_cap && rx_full_q)) begin
            rx_buf_q  <= rx_byte;    // RL5 RL10
            rx_full_q <= 1'b1;    // RL5 RL10
        end else if (rd_data && stat_rd_q) begin
            rx_full_q <= 1'b0;    // RL6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_q  <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            if (bit1_cap && rx_full_q)
                ovr_q <= 1'b1;    // RL23
            else if (rd_data && stat_rd_q)
                ovr_q <= 1'b0;
            if (bit1_cap && rx_full_q)
                drop_q <= 1'b1;    // RL23
            else if (state_q == SPM_IDLE)
                drop_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            select_fault_flag_q <= 1'b0;
        else if (select_fault_flag_set)
            select_fault_flag_q <= 1'b1;    // RL19
        else if (wr_ctrl && stat_rd_q)
            select_fault_flag_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Pin and interrupt outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q    <= 1'b0;
            sclk_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            irq_rx_q  <= 1'b0;
            irq_tx_q  <= 1'b0;
        end else begin
            sclk_q    <= (state_q == SPM_RUN && role) ? (sclk_q ^ ev) : clock_polarity_bit;    // RL8
            sclk_oe_q <= en & role;    // RL1
            mosi_oe_q <= en & role;    // RL1
            miso_oe_q <= en & ~role & ~ss_n_s;    // RL18
            irq_rx_q  <= (rx_full_q & ctrl_q[`SPM_C_RXIE])
                         | ((ovr_q | select_fault_flag_q) & stat_w_q[3]);    // RL20
            irq_tx_q  <= tx_empty_q & ctrl_q[`SPM_C_TXIE];    // RL20
        end
    end

    assign sclk_out = sclk_q;
    assign sclk_oe  = sclk_oe_q;
    assign mosi_out = txsh_q[7];
    assign mosi_oe  = mosi_oe_q;
    assign miso_out = txsh_q[7];
    assign miso_oe  = miso_oe_q;
    assign irq_rx   = irq_rx_q;
    assign irq_tx   = irq_tx_q;
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    localparam int START_MAX = `SPM_START_MAX;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_load_sets_empty: assert property (load && !wr_data |=> tx_empty_q && txsh_q == $past(tx_buf_q)) // RL3
        else $error("load did not set empty flag");
    a_write_clears_te: assert property (wr_data |=> !tx_empty_q) // RL7
        else $error("data write left empty flag set");
    a_rx_copy: assert property (done && !drop_q && !bit1_cap |=> rx_full_q && rx_buf_q == $past(rx_byte)) // RL5
        else $error("received byte not copied");
    a_rx_full_hold: assert property (rx_full_q && !(rd_data && stat_rd_q) |=> rx_full_q) // RL6
        else $error("receiver full cleared without sequence");
    a_ovr_keep: assert property (done && drop_q && !(rd_data && stat_rd_q)
                                 |=> rx_buf_q == $past(rx_buf_q) && ovr_q) // RL23
        else $error("overrun byte overwrote buffer");
    a_miso_float: assert property (!role && ss_n_s |=> !miso_oe) // RL18
        else $error("unselected target drives data");
    a_start_delay: assert property (role && load |-> ##[1:START_MAX] ev) // RL24
        else $error("controller start too late");
    a_msb_first: assert property (role && load |=> mosi_out == $past(tx_buf_q[7])) // RL21
        else $error("first bit not msb");
    a_role_clock: assert property (en && role ##1 en && role |-> sclk_oe) // RL1
        else $error("controller not driving clock");
    a_fault_flag: assert property (select_fault_flag_set |=> select_fault_flag_q && !en) // RL19
        else $error("select fault not flagged");

    c_ctrl_xfer: cover property (role && done);
    c_tgt_xfer: cover property (!role && done);
    c_overrun: cover property (bit1_cap && rx_full_q);
    c_fault: cover property (select_fault_flag_set);
    c_phase1: cover property (clock_phase_bit && done);
endmodule

`default_nettype wire

// >>> spm_defines.svh
// Purpose: Constants of the serial port block
// Assumes: Included by its bare name
// Notes:   Register byte address is four times the index
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SPM_IDX_CTRL    8'h10
`define SPM_IDX_STAT    8'h11
`define SPM_IDX_DATA    8'h12

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPM_C_RXIE      7
`define SPM_C_ROLE      5
`define SPM_C_CLOCK_POLARITY_BIT      4
`define SPM_C_CLOCK_PHASE_BIT      3
`define SPM_C_EN        1
`define SPM_C_TXIE      0
`define SPM_CTRL_RST    8'h00

// ----------------------------------------------------------------
// Status and control register fields
// ----------------------------------------------------------------
`define SPM_S_RXF       7
`define SPM_S_ERRIE     6
`define SPM_S_OVR       5
`define SPM_S_SELECT_FAULT_FLAG      4
`define SPM_S_TXE       3
`define SPM_S_MODFEN    2
`define SPM_S_RATE_HI   1
`define SPM_S_RATE_LO   0
`define SPM_STAT_W_RST  4'h0

// ----------------------------------------------------------------
// Serial clock dividers and timing
// ----------------------------------------------------------------
`define SPM_DIV_R0      8'd2
`define SPM_DIV_R1      8'd8
`define SPM_DIV_R2      8'd32
`define SPM_DIV_R3      8'd128
`define SPM_LAST_HALF   4'd15
`define SPM_START_MAX   128

`endif

// >>> spm_pkg.sv
// Purpose: Types of the serial port block
// Assumes: Nothing
// Notes:   Constants live in spm_defines.svh
`default_nettype none

package spm_pkg;
    typedef enum logic {
        SPM_IDLE,
        SPM_RUN
    } spm_state_t;
endpackage

`default_nettype wire

// >>> spm_baud.sv
// Purpose: Free-running serial clock half-bit tick generator
// Assumes: Runs only while the port is enabled as controller
// Notes:   One tick per half bit time
`include "spm_defines.svh"
`default_nettype none

module spm_baud (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] rate,
    output logic            tick
);
    logic [7:0] div;
    logic [6:0] lim;
    logic [6:0] cnt_q;
    logic       tick_q;

    // ----------------------------------------------------------------
    // Rate select
    // ----------------------------------------------------------------
    always_comb begin
        unique case (rate)
            2'd0: div = `SPM_DIV_R0;
            2'd1: div = `SPM_DIV_R1;
            2'd2: div = `SPM_DIV_R2;
            2'd3: div = `SPM_DIV_R3;
        endcase
        lim = div[7:1] - 7'd1;
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 7'd0;
            tick_q <= 1'b0;
        end else if (!run || cnt_q >= lim) begin
            cnt_q  <= 7'd0;
            tick_q <= run;
        end else begin
            cnt_q  <= cnt_q + 7'd1;
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;
endmodule

`default_nettype wire

// >>> spm_peer_model.sv
// Purpose: Far-side serial target used while the port is controller
// Assumes: Clock phase 0, polarity 0, pins sampled on the bus clock
// Notes:   Data line toggles every cycle while deselected
`default_nettype none

module spm_peer_model (
    input  wire logic       pclk,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Shift logic
    // ------------------------------------------------------------
    logic [7:0] sh_q   = 8'h00;
    logic [3:0] cnt_q  = 4'h0;
    logic       sel_q  = 1'b1;
    logic       sclk_q = 1'b0;

    initial miso = 1'b0;
    initial rx_byte = 8'h00;

    always @(posedge pclk) begin
        sel_q <= sel_n;
        sclk_q <= sclk;
        if (sel_n) begin
            miso <= ~miso;
        end else if (sel_q) begin
            sh_q <= tx_byte;
            miso <= tx_byte[7];
            cnt_q <= 4'h0;
        end else if (sclk && !sclk_q) begin
            sh_q <= {sh_q[6:0], mosi};
            cnt_q <= cnt_q + 4'h1;
        end else if (!sclk && sclk_q) begin
            if (cnt_q == 4'h8) begin
                rx_byte <= sh_q;
                sh_q <= tx_byte;
                miso <= tx_byte[7];
                cnt_q <= 4'h0;
            end else begin
                miso <= sh_q[7];
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb_spm_top.sv
// Purpose: Self-checking bench for the serial port block
// Assumes: Peer model answers in controller role; bench drives target role
// Notes:   Controller data checks run at the divide-by-8 rate
`include "spm_defines.svh"
`default_nettype none

module tb_spm_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [9:0] A_CTRL = {`SPM_IDX_CTRL, 2'b00};
    localparam logic [9:0] A_STAT = {`SPM_IDX_STAT, 2'b00};
    localparam logic [9:0] A_DATA = {`SPM_IDX_DATA, 2'b00};
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic        irq_rx, irq_tx, tb_sclk, tb_mosi, ss_n, peer_sel_n, peer_miso;
    logic        sclk_w, mosi_w, miso_w, er;
    logic [7:0]  peer_tx, peer_rx, rd;
    int          error_cnt = 0;
    int          total_checks = 0;

    assign sclk_w = sclk_oe ? sclk_out : tb_sclk;
    assign mosi_w = mosi_oe ? mosi_out : tb_mosi;
    assign miso_w = miso_oe ? miso_out : peer_miso;

    always #5 pclk = ~pclk;

    spm_top i_spm_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n),
        .irq_rx(irq_rx), .irq_tx(irq_tx)
    );

    spm_peer_model i_spm_peer_model (
        .pclk(pclk), .sclk(sclk_w), .mosi(mosi_w), .sel_n(peer_sel_n),
        .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic hang;
        error_cnt++;
        $display("ERROR %0t: wait timed out", $time);
        end_sim();
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    task automatic wait_irq;
        int n = 0;
        repeat (3) @(posedge pclk);
        while (irq_rx !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) hang();
    endtask

    // Bench acts as far controller in phase ph, eight bus cycles per half bit
    task automatic frame(input logic [7:0] m, input logic [7:0] exp, input logic mid,
                         input logic ph);
        logic [7:0] got;
        ss_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk({7'h0, miso_oe}, 8'h01);
        for (int i = 7; i >= 0; i--) begin
            if (ph)
                tb_sclk <= 1'b1;
            tb_mosi <= m[i];
            repeat (8) @(posedge pclk);
            got[i] = miso_w;
            tb_sclk <= ~ph;
            repeat (8) @(posedge pclk);
            if (!ph)
                tb_sclk <= 1'b0;
            if (mid && i == 4) begin
                wr(A_DATA, 8'h5a);
                rdchk(A_STAT, 8'h80);
            end
        end
        chk(got, exp);
        repeat (8) @(posedge pclk);
        ss_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({7'h0, miso_oe}, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdchk(A_CTRL, 8'h00);
        rdchk(A_STAT, 8'h08);
        apb(1'b0, 10'h04c, 8'h00);
        chk({er, rd[6:0]}, 8'h80);
        wr(A_STAT, 8'hff);
        rdchk(A_STAT, 8'h4f);
        wr(A_CTRL, 8'h01);
        repeat (2) @(posedge pclk);
        chk({7'h0, irq_tx}, 8'h01);
        wr(A_STAT, 8'h00);
    endtask

    task automatic t_ctrl;
        wr(A_STAT, 8'h01);
        wr(A_CTRL, 8'ha2);
        peer_tx <= 8'h3c;
        peer_sel_n <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({6'h0, sclk_oe, mosi_oe}, 8'h03);
        wr(A_DATA, 8'ha5);
        wr(A_DATA, 8'h96);
        rdchk(A_STAT, 8'h01);
        wait_irq();
        rdchk(A_STAT, 8'h89);
        rdchk(A_DATA, 8'h3c);
        chk(peer_rx, 8'ha5);
        wait_irq();
        rdchk(A_DATA, 8'h3c);
        rdchk(A_STAT, 8'h89);
        rdchk(A_DATA, 8'h3c);
        rdchk(A_STAT, 8'h09);
        chk(peer_rx, 8'h96);
    endtask

    task automatic t_rates;
        int n;
        int m;
        logic s;
        for (int r = 0; r < 4; r++) begin
            wr(A_STAT, 8'(r));
            wr(A_DATA, 8'h00);
            n = 0;
            while (sclk_out === 1'b0 && n < 300) begin
                @(posedge pclk);
                n++;
            end
            s = sclk_out;
            m = 0;
            while (sclk_out === s && m < 300) begin
                @(posedge pclk);
                m++;
            end
            chk({7'h0, n <= (2 << (2 * r)) + 1}, 8'h01);
            chk(8'(m), 8'(1 << (2 * r)));
            wait_irq();
            rdchk(A_STAT, 8'h88 | 8'(r));
            apb(1'b0, A_DATA, 8'h00);
        end
    endtask

    task automatic t_target;
        peer_sel_n <= 1'b1;
        wr(A_CTRL, 8'h80);
        wr(A_STAT, 8'h00);
        wr(A_CTRL, 8'h82);
        chk({6'h0, sclk_oe, miso_oe}, 8'h00);
        wr(A_DATA, 8'hc3);
        rdchk(A_STAT, 8'h08);
        frame(8'h69, 8'hc3, 1'b0, 1'b0);
        wait_irq();
        frame(8'h1e, 8'hc3, 1'b1, 1'b0);
        rdchk(A_STAT, 8'ha8);
        rdchk(A_DATA, 8'h69);
        frame(8'h0f, 8'h5a, 1'b0, 1'b0);
        wait_irq();
        rdchk(A_STAT, 8'h88);
        rdchk(A_DATA, 8'h0f);
        wr(A_CTRL, 8'h80);
        wr(A_CTRL, 8'h8a);
        frame(8'hc6, 8'h5a, 1'b0, 1'b1);
        rdchk(A_STAT, 8'h88);
        rdchk(A_DATA, 8'hc6);
        frame(8'h71, 8'h5a, 1'b0, 1'b1);
        rdchk(A_STAT, 8'h88);
        rdchk(A_DATA, 8'h71);
    endtask

    task automatic t_fault;
        wr(A_CTRL, 8'hb2);
        wr(A_STAT, 8'h44);
        chk({7'h0, sclk_out}, 8'h01);
        ss_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({7'h0, irq_rx}, 8'h01);
        ss_n <= 1'b1;
        rdchk(A_STAT, 8'h5c);
        rdchk(A_CTRL, 8'hb0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        tb_sclk = 1'b0;
        tb_mosi = 1'b0;
        ss_n = 1'b1;
        peer_sel_n = 1'b1;
        peer_tx = 8'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ctrl();
        t_rates();
        t_target();
        t_fault();
        end_sim();
    end
endmodule

`default_nettype wire
